//--- hw/ccpm_pkg.sv
// Shared constants for the capture/compare/PWM unit
package ccpm_pkg;
  // Register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register addresses
  localparam logic [3:0] ADR_CONTROL  = 4'h0;
  localparam logic [3:0] ADR_VALUE_LO = 4'h1;
  localparam logic [3:0] ADR_VALUE_HI = 4'h2;
  localparam logic [3:0] ADR_STATUS   = 4'h3;
  // Control register fields
  localparam int CTL_W       = 6;
  localparam int MODE_LSB    = 0;
  localparam int MODE_MSB    = 3;
  localparam int DUTY_LO_LSB = 4;
  localparam int DUTY_LO_MSB = 5;
  localparam logic [5:0] CTL_RESET = 6'h00;
  // Status register fields
  localparam int STS_FLAG_BIT = 0;
  // Value register and PWM duty widths
  localparam int VAL_W  = 16;
  localparam int DUTY_W = 10;
  localparam logic [15:0] VAL_RESET = 16'h0000;
  // Mode codes
  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_RSV1     = 4'h1;
  localparam logic [3:0] MODE_TOGGLE   = 4'h2;
  localparam logic [3:0] MODE_RSV3     = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4    = 4'h6;
  localparam logic [3:0] MODE_CAP_16   = 4'h7;
  localparam logic [3:0] MODE_SET_HI   = 4'h8;
  localparam logic [3:0] MODE_SET_LO   = 4'h9;
  localparam logic [3:0] MODE_SOFT     = 4'hA;
  localparam logic [3:0] MODE_TRIG     = 4'hB;
  // Edge prescaler selections and their final counts
  localparam logic [1:0] DIV_1  = 2'h0;
  localparam logic [1:0] DIV_4  = 2'h1;
  localparam logic [1:0] DIV_16 = 2'h2;
  localparam logic [3:0] LAST_1  = 4'h0;
  localparam logic [3:0] LAST_4  = 4'h3;
  localparam logic [3:0] LAST_16 = 4'hF;
  // Operating class, one-hot
  typedef enum logic [3:0] {
    CLS_OFF = 4'b0001,
    CLS_CAP = 4'b0010,
    CLS_CMP = 4'b0100,
    CLS_PWM = 4'b1000
  } ccpm_class_e;
endpackage : ccpm_pkg

//--- hw/ccpm_prescaler.sv
// Edge prescaler: passes one qualifying edge in 1, 4 or 16
`timescale 1ns/100ps
module ccpm_prescaler
  import ccpm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       clear,
  input  wire logic       edge_in,
  input  wire logic [1:0] div_sel,
  output logic            fire
);
  typedef struct packed {
    logic [3:0] cnt;
  } ccpm_psc_s;

  ccpm_psc_s  st_r;
  ccpm_psc_s  st_nxt;
  logic [3:0] last;

  // Final count of the selected ratio
  always_comb begin
    case (div_sel)
      DIV_4:   last = LAST_4;
      DIV_16:  last = LAST_16;
      default: last = LAST_1;
    endcase
  end

  // Combinational so the capture lands with its own edge
  assign fire = edge_in && (st_r.cnt == last);

  // Count edges; clear drops any partial count
  always_comb begin
    st_nxt = st_r;
    if (clear) begin
      st_nxt.cnt = 4'h0;
    end else if (fire) begin
      st_nxt.cnt = 4'h0;
    end else if (edge_in) begin
      st_nxt.cnt = st_r.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : ccpm_prescaler

//--- hw/ccpm_unit.sv
// Capture/compare/PWM unit with its register port
`timescale 1ns/100ps
module ccpm_unit
  import ccpm_pkg::*;
(
  input  wire logic              MCLK,
  input  wire logic              ARST_N,
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [DATA_W-1:0] REG_RDATA,
  input  wire logic [VAL_W-1:0]  TIMER_COUNT,
  input  wire logic              PIN_IN,
  output logic                   PIN_OUT,
  output logic                   PIN_OE_N,
  output logic                   EVENT_FLAG,
  output logic                   SPECIAL_TRIG
);
  typedef struct packed {
    logic [CTL_W-1:0]  ctl;
    logic [VAL_W-1:0]  val;
    logic              flag;
    logic [1:0]        sync;
    logic              pin_d;
    logic              match_d;
    logic [DUTY_W-1:0] duty;
    logic              pin_out;
    logic              oe_n;
    logic              trig;
    logic [3:0]        mode_d;
    logic [DATA_W-1:0] rdata;
  } ccpm_state_s;

  ccpm_state_s st_r;
  ccpm_state_s st_nxt;
  logic [3:0]  mode;
  ccpm_class_e cls;
  logic        rise;
  logic        fall;
  logic        edge_q;
  logic        fire;
  logic        psc_clear;
  logic [1:0]  div_sel;
  logic        hit;
  logic        match_now;
  logic        entry;

  // Decode a mode code into its operating class
  function automatic ccpm_class_e mode_class(input logic [3:0] m);
    case (m)
      MODE_TOGGLE, MODE_SET_HI, MODE_SET_LO, MODE_SOFT, MODE_TRIG:
        mode_class = CLS_CMP;
      MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_4, MODE_CAP_16:
        mode_class = CLS_CAP;
      MODE_OFF, MODE_RSV1, MODE_RSV3:
        mode_class = CLS_OFF;
      default:
        mode_class = CLS_PWM;
    endcase
  endfunction : mode_class

  assign mode  = st_r.ctl[MODE_MSB:MODE_LSB];
  assign cls   = mode_class(mode);
  assign entry = (mode != st_r.mode_d);

  // Edges seen on the second synchroniser stage only
  assign rise = st_r.sync[1] && !st_r.pin_d;
  assign fall = !st_r.sync[1] && st_r.pin_d;

  // Pick the qualifying edge and prescale ratio
  always_comb begin
    edge_q  = 1'b0;
    div_sel = DIV_1;
    case (mode)
      MODE_CAP_FALL: edge_q = fall;
      MODE_CAP_RISE: edge_q = rise;
      MODE_CAP_4: begin
        edge_q  = rise;
        div_sel = DIV_4;
      end
      MODE_CAP_16: begin
        edge_q  = rise;
        div_sel = DIV_16;
      end
      default: edge_q = 1'b0;
    endcase
  end

  // Any mode change restarts the prescaler count
  assign psc_clear = entry || (cls != CLS_CAP);

  ccpm_prescaler ccpm_prescaler_inst (
    .clk     (MCLK),
    .arst_n  (ARST_N),
    .clear   (psc_clear),
    .edge_in (edge_q),
    .div_sel (div_sel),
    .fire    (fire)
  );

  // One hit per match episode, not one per cycle of equality
  assign match_now = (cls == CLS_CMP) && (TIMER_COUNT == st_r.val);
  assign hit       = match_now && !st_r.match_d;

  // Next-state logic for the whole unit
  always_comb begin
    st_nxt         = st_r;
    st_nxt.sync    = {st_r.sync[0], PIN_IN};
    st_nxt.pin_d   = st_r.sync[1];
    st_nxt.mode_d  = mode;
    st_nxt.trig    = 1'b0;
    st_nxt.rdata   = '0;
    st_nxt.match_d = match_now;

    // Software writes
    if (REG_WR) begin
      case (REG_ADDR)
        ADR_CONTROL:  st_nxt.ctl = REG_WDATA[CTL_W-1:0];
        ADR_VALUE_LO: st_nxt.val[DATA_W-1:0] = REG_WDATA;
        ADR_VALUE_HI: st_nxt.val[VAL_W-1:DATA_W] = REG_WDATA;
        ADR_STATUS: begin
          if (REG_WDATA[STS_FLAG_BIT]) begin
            st_nxt.flag = 1'b0;
          end
        end
        default: st_nxt.ctl = st_nxt.ctl;
      endcase
    end

    // Mode behaviour; hardware sets win over software clears
    case (cls)
      CLS_OFF: begin
        st_nxt.pin_out = 1'b0;
        st_nxt.oe_n    = 1'b1;
        st_nxt.duty    = '0;
      end
      CLS_CAP: begin
        st_nxt.oe_n = 1'b1;
        if (fire) begin
          st_nxt.val  = TIMER_COUNT;
          st_nxt.flag = 1'b1;
        end
      end
      CLS_CMP: begin
        case (mode)
          MODE_TOGGLE: begin
            st_nxt.oe_n = 1'b0;
            if (hit) begin
              st_nxt.pin_out = !st_r.pin_out;
            end
          end
          MODE_SET_HI: begin
            st_nxt.oe_n = 1'b0;
            if (entry) begin
              st_nxt.pin_out = 1'b0;
            end else if (hit) begin
              st_nxt.pin_out = 1'b1;
            end
          end
          MODE_SET_LO: begin
            st_nxt.oe_n = 1'b0;
            if (entry) begin
              st_nxt.pin_out = 1'b1;
            end else if (hit) begin
              st_nxt.pin_out = 1'b0;
            end
          end
          MODE_TRIG: begin
            st_nxt.oe_n = 1'b1;
            st_nxt.trig = hit;
          end
          default: st_nxt.oe_n = 1'b1;
        endcase
        if (hit) begin
          st_nxt.flag = 1'b1;
        end
      end
      default: begin
        // Duty reloads at period start to avoid glitched pulses
        st_nxt.oe_n = 1'b0;
        if (TIMER_COUNT[DUTY_W-1:0] == '0) begin
          st_nxt.duty = {st_r.val[DATA_W-1:0],
                         st_r.ctl[DUTY_LO_MSB:DUTY_LO_LSB]};
        end
        st_nxt.pin_out = (TIMER_COUNT[DUTY_W-1:0] < st_r.duty);
      end
    endcase

    // Read data for the next cycle; unmapped reads return zero
    if (REG_RD) begin
      case (REG_ADDR)
        ADR_CONTROL:  st_nxt.rdata = {2'h0, st_r.ctl};
        ADR_VALUE_LO: st_nxt.rdata = st_r.val[DATA_W-1:0];
        ADR_VALUE_HI: st_nxt.rdata = st_r.val[VAL_W-1:DATA_W];
        ADR_STATUS:   st_nxt.rdata = {7'h00, st_r.flag};
        default:      st_nxt.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r        <= '0;
      st_r.ctl    <= CTL_RESET;
      st_r.val    <= VAL_RESET;
      st_r.oe_n   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign REG_RDATA    = st_r.rdata;
  assign PIN_OUT      = st_r.pin_out;
  assign PIN_OE_N     = st_r.oe_n;
  assign EVENT_FLAG   = st_r.flag;
  assign SPECIAL_TRIG = st_r.trig;

  // Checks on the unit's outputs and on its internal capture signals
  a_ctl_top_zero: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    REG_RD && REG_ADDR == ADR_CONTROL |=> REG_RDATA[7:6] == 2'h0)
    else $error("control top bits not zero");

  a_disable_release: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    mode == MODE_OFF |=> PIN_OE_N && !PIN_OUT)
    else $error("disabled unit still drives pin");

  a_toggle_pin: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    mode == MODE_TOGGLE && hit |=> PIN_OUT != $past(PIN_OUT)
      && EVENT_FLAG)
    else $error("toggle match did not toggle pin");

  a_fall_capture: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    mode == MODE_CAP_FALL && !entry && fall
      |=> st_r.val == $past(TIMER_COUNT) && EVENT_FLAG)
    else $error("falling edge not captured");

  a_rise_capture: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    mode == MODE_CAP_RISE && !entry && rise |-> fire)
    else $error("rising edge not captured");

  a_quad_skip: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    mode == MODE_CAP_4 && fire |=> !fire [*3])
    else $error("prescale four fired too soon");

  // Sixteen edges need far more than eight cycles at the synchroniser
  a_sixteen_skip: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    mode == MODE_CAP_16 && fire |=> !fire [*8])
    else $error("prescale sixteen fired too soon");

  a_set_high: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    mode == MODE_SET_HI && !entry && hit |=> PIN_OUT && !PIN_OE_N)
    else $error("match did not drive pin high");

  a_set_low: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    mode == MODE_SET_LO && entry |=> PIN_OUT ##1 1'b1)
    else $error("entry did not drive pin high");

  a_soft_release: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    mode == MODE_SOFT && hit |=> PIN_OE_N && EVENT_FLAG)
    else $error("soft compare drove pin or missed flag");

  a_trig_pulse: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    mode == MODE_TRIG && hit |=> SPECIAL_TRIG ##1 !SPECIAL_TRIG)
    else $error("special trigger not a single pulse");

  a_pwm_level: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    cls == CLS_PWM && TIMER_COUNT[DUTY_W-1:0] < st_r.duty
      |=> PIN_OUT)
    else $error("PWM output low inside duty");

  a_pwm_drive: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    cls == CLS_PWM |=> !PIN_OE_N)
    else $error("PWM mode left pin undriven");

  // Reserved codes must behave exactly like the disabled code
  a_reserved_off: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    (mode == MODE_RSV1 || mode == MODE_RSV3) |=> PIN_OE_N && !PIN_OUT)
    else $error("reserved mode drove pin");

  a_flag_sticky: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    EVENT_FLAG && !(REG_WR && REG_ADDR == ADR_STATUS
      && REG_WDATA[STS_FLAG_BIT]) |=> EVENT_FLAG)
    else $error("event flag dropped without a clear");
endmodule : ccpm_unit

//--- bench/ccpm_pin_model.sv
// Far-side pin model: makes capture edges, yields the wire to the unit
`timescale 1ns/100ps
module ccpm_pin_model (
  input  wire logic clk,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output logic      pin_level
);
  logic drive_val = 1'b0;
  // The unit owns the wire whenever its enable is low
  assign pin_level = pin_oe_n ? drive_val : pin_out;
  // Pulse train; width w lets the far side be quick or slow
  task automatic pulses(input int n, input int w);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      drive_val <= 1'b1;
      repeat (w) @(posedge clk);
      drive_val <= 1'b0;
      repeat (w) @(posedge clk);
    end
  endtask : pulses
endmodule : ccpm_pin_model

//--- bench/test_ccp_mode_control.sv
// Self-checking bench for the capture/compare/PWM unit
`timescale 1ns/100ps
module test_ccp_mode_control
  import ccpm_pkg::*;
;
  logic              mclk, arst_n, reg_wr, reg_rd, pin_in;
  logic              pin_out, pin_oe_n, event_flag, special_trig;
  logic              rd_seen = 1'b0;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [VAL_W-1:0]  timer_cnt, t;
  logic [15:0]       seed = 16'h0026;
  logic [9:0]        duty;
  logic [3:0]        m;
  logic [7:0]        exp_q[$];
  // Compare table: mode, enable_n, pin on entry, pin after hit, flag, trig
  logic [8:0] cmp_tab [7] = '{9'h106, 9'h12A, 9'h046, 9'h152, 9'h173,
                              9'h030, 9'h070};
  int err_count, checks_done, cycles, trig_cnt, cnt, n;

  ccpm_unit ccpm_unit_inst (.MCLK(mclk), .ARST_N(arst_n),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .TIMER_COUNT(timer_cnt),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
    .EVENT_FLAG(event_flag), .SPECIAL_TRIG(special_trig));
  ccpm_pin_model ccpm_pin_model_inst (.clk(mclk), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_level(pin_in));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [15:0] xs();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction : xs

  task automatic final_report();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd

  task automatic chk_pin(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t level %b expected %b", $time, got, exp);
    end
  endtask : chk_pin

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // Expected data is queued when the read is issued
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    exp_q.push_back(exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask : rd

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    rd_seen <= reg_rd;
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      chk_rd(reg_rdata, exp_q.pop_front());
    end
    if (special_trig === 1'b1) trig_cnt++;
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    timer_cnt = '0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    // Reset values, unmapped place, unimplemented control bits
    rd(ADR_CONTROL, 8'h00);
    rd(ADR_VALUE_HI, 8'h00);
    rd(ADR_STATUS, 8'h00);
    rd(4'hF, 8'h00);
    wr(ADR_CONTROL, 8'hFF);
    rd(ADR_CONTROL, 8'h3F);
    // Capture modes; timer held so the captured count is known
    for (int i = 0; i < 4; i++) begin
      wr(ADR_CONTROL, 8'h00);
      wr(ADR_STATUS, 8'h01);
      t = xs();
      timer_cnt <= t;
      wr(ADR_CONTROL, 8'h04 + 8'(i));
      n = (i < 2) ? 1 : (i == 2) ? 4 : 16;
      ccpm_pin_model_inst.pulses(n - 1, 3 + i);
      if (n > 1) rd(ADR_STATUS, 8'h00);
      ccpm_pin_model_inst.pulses(1, 3 + i);
      repeat (4) @(posedge mclk);
      rd(ADR_VALUE_LO, t[7:0]);
      rd(ADR_VALUE_HI, t[15:8]);
      rd(ADR_STATUS, 8'h01);
      chk_pin(event_flag, 1'b1);
    end
    // Compare modes and the reserved codes, one table row each
    for (int i = 0; i < 7; i++) begin
      m = cmp_tab[i][8:5];
      wr(ADR_CONTROL, 8'h00);
      timer_cnt <= '0;
      wr(ADR_STATUS, 8'h01);
      chk_pin(pin_oe_n, 1'b1);
      t = xs() | 16'h0001;
      wr(ADR_VALUE_LO, t[7:0]);
      wr(ADR_VALUE_HI, t[15:8]);
      rd(ADR_VALUE_HI, t[15:8]);
      chk_pin(event_flag, 1'b0);
      trig_cnt = 0;
      wr(ADR_CONTROL, {4'h0, m});
      repeat (3) @(posedge mclk);
      chk_pin(pin_oe_n, cmp_tab[i][4]);
      if (!cmp_tab[i][4]) chk_pin(pin_out, cmp_tab[i][3]);
      timer_cnt <= t;
      repeat (4) @(posedge mclk);
      if (!cmp_tab[i][4]) chk_pin(pin_out, cmp_tab[i][2]);
      chk_pin(trig_cnt == int'(cmp_tab[i][0]), 1'b1);
      rd(ADR_STATUS, {7'h00, cmp_tab[i][1]});
      chk_pin(event_flag, cmp_tab[i][1]);
    end
    // PWM: count high cycles over one whole period after the latch
    for (int i = 0; i < 4; i++) begin
      t = xs() | 16'h0001;
      duty = {t[7:0], 2'(i)};
      wr(ADR_VALUE_LO, t[7:0]);
      wr(ADR_CONTROL, {2'b00, 2'(i), 4'hC + 4'(i)});
      cnt = 0;
      for (int k = 0; k < 2050; k++) begin
        @(posedge mclk);
        if (k >= 1026 && pin_out === 1'b1) cnt++;
        timer_cnt <= {6'h00, 10'(k)};
      end
      chk_pin(cnt == int'(duty), 1'b1);
      chk_pin(pin_oe_n, 1'b0);
    end
    wr(ADR_CONTROL, 8'h00);
    repeat (3) @(posedge mclk);
    final_report();
  end
endmodule : test_ccp_mode_control
